// file: power_control.sv
// Power management control register with sleep mode selection
//
// Our own choice: strobed register access.
module power_control (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Register bus
	input  wire logic [7:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_half,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output wire logic [31:0] bus_rdata,
	// Power events
	input  wire logic        core_deep_sleep_request,
	input  wire logic        standby_wakeup,
	input  wire logic        osc_periph_active,
	input  wire logic        detector_lock,
	// Controls
	output wire logic        regulator_high,
	output wire logic        regulator_lp_on,
	output wire logic        backup_write_grant,
	output wire logic        lvd_enable,
	output wire logic [8:0]  lvd_threshold,
	output wire logic        standby_flag_clear,
	output wire logic        wakeup_flag_clear,
	output wire logic        deep_sleep_active,
	output wire logic        standby_active,
	output wire logic        standby_flag
);

	localparam logic [31:0] RST = power_control_pkg::CTL_RESET;

	// Field registers
	logic [1:0]  vs_ff;
	logic        bkp_ff;
	logic [2:0]  thr_ff;
	logic        low_voltage_detect_enable_ff;
	logic        stbsel_ff;
	logic        lp_ff;
	logic [1:0]  nxt_vs;
	logic        nxt_bkp;
	logic [2:0]  nxt_thr;
	logic        nxt_low_voltage_detect_enable;
	logic        nxt_stbsel;
	logic        nxt_lp;

	// Output registers
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        reg_high_ff;
	logic        reg_lp_ff;
	logic        nxt_reg_lp;
	logic        bkp_grant_ff;
	logic        lvd_en_ff;
	logic [8:0]  lvd_thr_ff;
	logic        stb_clr_ff;
	logic        wu_clr_ff;
	logic        sflag_ff;
	logic        nxt_sflag;

	power_control_pkg::pmu_state_type state_ff;
	power_control_pkg::pmu_state_type nxt_state;

	// Address decode and lanes
	wire        hit_ctl;
	wire        hit_status;
	wire        lo_lane;
	wire        ctl_wr;
	wire        clr_stb;
	wire        clr_wu;
	wire        lvd_wr;
	wire [31:0] ctl_word;
	wire [31:0] status_word;
	wire [8:0]  thr_level;
	wire        enter_stby;

	assign hit_ctl    = bus_addr[7:2] == power_control_pkg::CTL_OFFSET[7:2];
	assign hit_status = bus_addr[7:2] == power_control_pkg::STATUS_OFFSET[7:2];
	// A half write to the upper half only touches reserved bits
	assign lo_lane    = !bus_half || !bus_addr[1];
	assign ctl_wr     = bus_wr && hit_ctl && lo_lane;
	assign clr_stb    = ctl_wr && bus_wdata[power_control_pkg::STBCLR_BIT];
	assign clr_wu     = ctl_wr && bus_wdata[power_control_pkg::WUCLR_BIT];
	assign lvd_wr     = ctl_wr && !detector_lock;

	// Clear bits and reserved bits read as zero
	assign ctl_word = {16'h0000, vs_ff, 5'h00, bkp_ff, thr_ff,
		low_voltage_detect_enable_ff, 2'h0, stbsel_ff, lp_ff};
	assign status_word = {28'h0000000, sflag_ff, reg_lp_ff,
		state_ff == power_control_pkg::ST_STBY,
		state_ff == power_control_pkg::ST_DEEP};

	assign enter_stby = state_ff == power_control_pkg::ST_RUN &&
		core_deep_sleep_request && stbsel_ff;

	lvd_threshold_decode u_thr (
		.code  (thr_ff),
		.level (thr_level)
	);

	// Next field values
	always_comb begin
		nxt_vs     = vs_ff;
		nxt_bkp    = bkp_ff;
		nxt_thr    = thr_ff;
		nxt_low_voltage_detect_enable  = low_voltage_detect_enable_ff;
		nxt_stbsel = stbsel_ff;
		nxt_lp     = lp_ff;
		if (standby_wakeup) begin
			nxt_vs     = RST[power_control_pkg::VS_HI:power_control_pkg::VS_LO];
			nxt_bkp    = RST[power_control_pkg::BKP_BIT];
			nxt_thr    = RST[power_control_pkg::THR_HI:power_control_pkg::THR_LO];
			nxt_low_voltage_detect_enable  = RST[power_control_pkg::LOW_VOLTAGE_DETECT_ENABLE_BIT];
			nxt_stbsel = RST[power_control_pkg::STBSEL_BIT];
			nxt_lp     = RST[power_control_pkg::LP_BIT];
		end else if (ctl_wr) begin
			nxt_vs     = bus_wdata[power_control_pkg::VS_HI:power_control_pkg::VS_LO];
			nxt_bkp    = bus_wdata[power_control_pkg::BKP_BIT];
			nxt_stbsel = bus_wdata[power_control_pkg::STBSEL_BIT];
			nxt_lp     = bus_wdata[power_control_pkg::LP_BIT];
			if (lvd_wr) begin
				nxt_thr   = bus_wdata[power_control_pkg::THR_HI:power_control_pkg::THR_LO];
				nxt_low_voltage_detect_enable = bus_wdata[power_control_pkg::LOW_VOLTAGE_DETECT_ENABLE_BIT];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (bus_rd && hit_ctl) begin
			nxt_rdata = ctl_word;
		end else if (bus_rd && hit_status) begin
			nxt_rdata = status_word;
		end
	end

	// Sleep mode sequencing
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			power_control_pkg::ST_RUN: begin
				if (core_deep_sleep_request) begin
					nxt_state = stbsel_ff ? power_control_pkg::ST_STBY
						: power_control_pkg::ST_DEEP;
				end
			end
			power_control_pkg::ST_DEEP: begin
				if (!core_deep_sleep_request) begin
					nxt_state = power_control_pkg::ST_RUN;
				end
			end
			power_control_pkg::ST_STBY: begin
				if (standby_wakeup) begin
					nxt_state = power_control_pkg::ST_RUN;
				end
			end
			default: begin
				nxt_state = power_control_pkg::ST_RUN;
			end
		endcase
	end

	// Oscillator users keep the regulator out of low power
	assign nxt_reg_lp = nxt_state == power_control_pkg::ST_DEEP &&
		lp_ff && !osc_periph_active;

	// Entry to standby wins over a clear in the same cycle
	assign nxt_sflag = enter_stby || (sflag_ff && !clr_stb);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			vs_ff     <= RST[power_control_pkg::VS_HI:power_control_pkg::VS_LO];
			bkp_ff    <= RST[power_control_pkg::BKP_BIT];
			thr_ff    <= RST[power_control_pkg::THR_HI:power_control_pkg::THR_LO];
			low_voltage_detect_enable_ff  <= RST[power_control_pkg::LOW_VOLTAGE_DETECT_ENABLE_BIT];
			stbsel_ff <= RST[power_control_pkg::STBSEL_BIT];
			lp_ff     <= RST[power_control_pkg::LP_BIT];
		end else begin
			vs_ff     <= nxt_vs;
			bkp_ff    <= nxt_bkp;
			thr_ff    <= nxt_thr;
			low_voltage_detect_enable_ff  <= nxt_low_voltage_detect_enable;
			stbsel_ff <= nxt_stbsel;
			lp_ff     <= nxt_lp;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= power_control_pkg::ST_RUN;
			sflag_ff <= 1'b0;
			reg_lp_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sflag_ff <= nxt_sflag;
			reg_lp_ff <= nxt_reg_lp;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff     <= 32'h0000_0000;
			reg_high_ff  <= 1'b1;
			bkp_grant_ff <= 1'b0;
			lvd_en_ff    <= 1'b0;
			lvd_thr_ff   <= power_control_pkg::THR_MV10[0];
			stb_clr_ff   <= 1'b0;
			wu_clr_ff    <= 1'b0;
		end else begin
			rdata_ff     <= nxt_rdata;
			reg_high_ff  <= !vs_ff[1];
			bkp_grant_ff <= bkp_ff;
			lvd_en_ff    <= low_voltage_detect_enable_ff && !standby_active;
			lvd_thr_ff   <= thr_level;
			stb_clr_ff   <= clr_stb;
			wu_clr_ff    <= clr_wu;
		end
	end

	assign bus_rdata          = rdata_ff;
	assign regulator_high     = reg_high_ff;
	assign regulator_lp_on    = reg_lp_ff;
	assign backup_write_grant = bkp_grant_ff;
	assign lvd_enable         = lvd_en_ff;
	assign lvd_threshold      = lvd_thr_ff;
	assign standby_flag_clear = stb_clr_ff;
	assign wakeup_flag_clear  = wu_clr_ff;
	// One-hot state bits drive the mode outputs straight from the register
	assign deep_sleep_active  = state_ff[1];
	assign standby_active     = state_ff[2];
	assign standby_flag       = sflag_ff;

	// Checks
	sequence s_wake;
		standby_wakeup && !ctl_wr;
	endsequence

	sequence s_req_deep;
		state_ff == power_control_pkg::ST_RUN && core_deep_sleep_request;
	endsequence

	property p_wake_reset;
		@(posedge clk_sys) disable iff (!rst_n)
		s_wake |=> ctl_word == RST;
	endproperty
	a_wake_reset: assert property (p_wake_reset)
		else $error("control word not at reset value after wakeup");

	property p_half_write;
		@(posedge clk_sys) disable iff (!rst_n)
		bus_wr && hit_ctl && bus_half && !bus_addr[1] && !standby_wakeup
		|=> lp_ff == $past(bus_wdata[0]) && stbsel_ff == $past(bus_wdata[1]);
	endproperty
	a_half_write: assert property (p_half_write)
		else $error("half-word write not applied");

	property p_volt;
		@(posedge clk_sys) disable iff (!rst_n)
		##1 regulator_high == !$past(vs_ff[1]);
	endproperty
	a_volt: assert property (p_volt)
		else $error("regulator voltage level wrong");

	property p_backup;
		@(posedge clk_sys) disable iff (!rst_n)
		!bkp_ff |=> !backup_write_grant;
	endproperty
	a_backup: assert property (p_backup)
		else $error("backup writes granted while disabled");

	property p_thr_ends;
		@(posedge clk_sys) disable iff (!rst_n)
		(thr_ff == 3'h0 |=> lvd_threshold == 9'h0D2) and
		(thr_ff == 3'h7 |=> lvd_threshold == 9'h136);
	endproperty
	a_thr_ends: assert property (p_thr_ends)
		else $error("threshold level wrong");

	property p_lvd_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!low_voltage_detect_enable_ff |=> !lvd_enable;
	endproperty
	a_lvd_off: assert property (p_lvd_off)
		else $error("detector running while disabled");

	property p_lock;
		@(posedge clk_sys) disable iff (!rst_n)
		ctl_wr && detector_lock && !standby_wakeup
		|=> $stable(thr_ff) && $stable(low_voltage_detect_enable_ff);
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked detector fields changed");

	property p_stb_clr;
		@(posedge clk_sys) disable iff (!rst_n)
		clr_stb |=> standby_flag_clear ##1
			(!standby_flag_clear || $past(clr_stb));
	endproperty
	a_stb_clr: assert property (p_stb_clr)
		else $error("standby clear pulse wrong");

	property p_clr_read;
		@(posedge clk_sys) disable iff (!rst_n)
		bus_rd && hit_ctl |=> bus_rdata[3:2] == 2'h0 &&
			bus_rdata[31:16] == 16'h0000 && bus_rdata[13:9] == 5'h00;
	endproperty
	a_clr_read: assert property (p_clr_read)
		else $error("clear or reserved bits read nonzero");

	property p_mode;
		@(posedge clk_sys) disable iff (!rst_n)
		s_req_deep |=> (deep_sleep_active == !$past(stbsel_ff)) &&
			(standby_active == $past(stbsel_ff));
	endproperty
	a_mode: assert property (p_mode)
		else $error("wrong sleep mode entered");

	property p_reg_lp;
		@(posedge clk_sys) disable iff (!rst_n)
		deep_sleep_active && core_deep_sleep_request && !lp_ff
		|=> !regulator_lp_on;
	endproperty
	a_reg_lp: assert property (p_reg_lp)
		else $error("regulator low power while not selected");

	property p_osc_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		osc_periph_active |=> !regulator_lp_on;
	endproperty
	a_osc_hold: assert property (p_osc_hold)
		else $error("regulator low power while oscillator in use");

	property p_sflag_keep;
		@(posedge clk_sys) disable iff (!rst_n)
		standby_flag && !clr_stb |=> standby_flag;
	endproperty
	a_sflag_keep: assert property (p_sflag_keep)
		else $error("standby flag lost without clear");

endmodule // power_control

// file: power_control_pkg.sv
// Constants and types for the power management control register block
package power_control_pkg;

	localparam logic [7:0]  CTL_OFFSET    = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET = 8'h08;
	localparam logic [31:0] CTL_RESET     = 32'h0000_4000;

	localparam int VS_HI     = 15;
	localparam int VS_LO     = 14;
	localparam int BKP_BIT   = 8;
	localparam int THR_HI    = 7;
	localparam int THR_LO    = 5;
	localparam int LOW_VOLTAGE_DETECT_ENABLE_BIT = 4;
	localparam int STBCLR_BIT = 3;
	localparam int WUCLR_BIT = 2;
	localparam int STBSEL_BIT = 1;
	localparam int LP_BIT    = 0;

	localparam int ST_DEEP_BIT  = 0;
	localparam int ST_STBY_BIT  = 1;
	localparam int ST_RLP_BIT   = 2;
	localparam int ST_SFLAG_BIT = 3;

	// Thresholds in units of 10 mV, index is the threshold code
	localparam logic [8:0] THR_MV10 [8] = '{
		9'h0D2, 9'h0E6, 9'h0F0, 9'h104,
		9'h10E, 9'h122, 9'h12C, 9'h136
	};

	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,
		ST_DEEP = 3'b010,
		ST_STBY = 3'b100
	} pmu_state_type;

endpackage

// file: lvd_threshold_decode.sv
// Low-voltage detector threshold code to level decoder
module lvd_threshold_decode (
	// Threshold code
	input  wire logic [2:0] code,
	// Threshold level in 10 mV units
	output wire logic [8:0] level
);

	assign level = power_control_pkg::THR_MV10[code];

endmodule // lvd_threshold_decode

// file: core_model.sv
// Core model driving the deep sleep request and standby wakeup
module core_model (
	// Clock
	input  wire logic clk_sys,
	// Sleep link
	output logic      core_deep_sleep_request,
	output logic      standby_wakeup
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		core_deep_sleep_request = 1'b0;
		standby_wakeup          = 1'b0;
	end
	// Request level after a delay, held until changed
	task automatic req(input logic v, input int lat);
		repeat (lat + 1) @(posedge clk_sys);
		core_deep_sleep_request <= v;
	endtask
	// One-cycle wakeup pulse after a delay
	task automatic wake(input int lat);
		repeat (lat + 1) @(posedge clk_sys);
		standby_wakeup <= 1'b1;
		@(posedge clk_sys);
		standby_wakeup <= 1'b0;
	endtask
endmodule // core_model

// file: tb_power_control.sv
// Self-checking bench for the power control register block
module tb_power_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys;
	logic        rst_n;
	logic        bus_half;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_addr;
	logic [31:0] bus_wdata;
	logic        osc_periph_active;
	logic        detector_lock;
	wire  [31:0] bus_rdata;
	wire         core_deep_sleep_request;
	wire         standby_wakeup;
	wire         regulator_high;
	wire         regulator_lp_on;
	wire         backup_write_grant;
	wire         lvd_enable;
	wire  [8:0]  lvd_threshold;
	wire         standby_flag_clear;
	wire         wakeup_flag_clear;
	wire         deep_sleep_active;
	wire         standby_active;
	wire         standby_flag;
	int          fails = 0;
	int          compares = 0;
	integer      seed = 32'h3C5F5AFD;
	int          ctl = 32'h4000;
	int          thr [8] = '{210, 230, 240, 260, 270, 290, 300, 310};
	logic [31:0] r;
	power_control DUT (
		.clk_sys, .rst_n, .bus_addr, .bus_wdata, .bus_half,
		.bus_wr, .bus_rd, .bus_rdata, .core_deep_sleep_request,
		.standby_wakeup, .osc_periph_active, .detector_lock,
		.regulator_high, .regulator_lp_on, .backup_write_grant,
		.lvd_enable, .lvd_threshold, .standby_flag_clear,
		.wakeup_flag_clear, .deep_sleep_active, .standby_active,
		.standby_flag
	);
	core_model partner (
		.clk_sys, .core_deep_sleep_request, .standby_wakeup
	);
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Write, then model the register
	task automatic wr(input logic [31:0] w, input logic h);
		int m;
		m = detector_lock ? 32'hC103 : 32'hC1F3;
		@(posedge clk_sys);
		bus_wr <= 1'b1;
		bus_addr <= 8'h00;
		bus_wdata <= w;
		bus_half <= h;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		#1;
		chk("stby clr", w[3], standby_flag_clear);
		chk("wake clr", w[2], wakeup_flag_clear);
		ctl = (ctl & ~m) | (w & m);
	endtask
	task automatic rdchk(input logic [7:0] a, input int e);
		@(posedge clk_sys);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		chk("rdata", e, bus_rdata);
	endtask
	task automatic outs();
		chk("reg high", !ctl[15], regulator_high);
		chk("backup", ctl[8], backup_write_grant);
		chk("lvd en", ctl[4], lvd_enable);
		chk("lvd thr", thr[ctl[7:5]], lvd_threshold);
		chk("lp on", 0, regulator_lp_on);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		fails++;
		stop_test();
	end
	initial begin
		rst_n = 1'b0;
		bus_half = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		osc_periph_active = 1'b0;
		detector_lock = 1'b0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdchk(8'h00, 32'h4000);
		outs();
		$display("reset test done");
		repeat (40) begin
			r = $random(seed);
			detector_lock <= r[31];
			#1;
			wr(r & 32'hC1FF, r[30]);
			rdchk(8'h00, ctl);
			outs();
		end
		$display("write test done");
		detector_lock <= 1'b0;
		#1;
		wr(32'h4001, 1'b0);
		for (int i = 0; i < 2; i++) begin
			osc_periph_active <= i[0];
			partner.req(1'b1, $random(seed) & 3);
			repeat (6) @(posedge clk_sys);
			#1;
			chk("deep", 1, deep_sleep_active);
			chk("lp on", !i[0], regulator_lp_on);
			partner.req(1'b0, 0);
			repeat (2) @(posedge clk_sys);
			#1;
			chk("deep", 0, deep_sleep_active);
			chk("lp on", 0, regulator_lp_on);
		end
		wr(32'h4012, 1'b0);
		partner.req(1'b1, 0);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("stby", 1, standby_active);
		chk("sflag", 1, standby_flag);
		chk("lvd en", 0, lvd_enable);
		partner.req(1'b0, 0);
		partner.wake($random(seed) & 3);
		repeat (2) @(posedge clk_sys);
		#1;
		ctl = 32'h4000;
		chk("stby", 0, standby_active);
		chk("sflag", 1, standby_flag);
		rdchk(8'h00, ctl);
		rdchk(8'h08, 32'h8);
		rdchk(8'h10, 0);
		wr(32'h4008, 1'b0);
		chk("sflag", 0, standby_flag);
		$display("sleep test done");
		stop_test();
	end
endmodule // tb_power_control
